// File: hw/gps_defines.svh
`ifndef GPS_DEFINES_SVH
`define GPS_DEFINES_SVH

// register byte offsets
`define GPS_STATUS_OFS        8'ha4
`define GPS_COMMAND_OFS       8'ha8

// reset values
`define GPS_STATUS_RESET      32'h1f00_0217
`define GPS_COMMAND_RESET     32'h0000_0000

// field positions
`define GPS_QUEUE_LSB         24
`define GPS_SIDEBAND_BIT      9
`define GPS_PORT_EN_BIT       8
`define GPS_HIGH_ADDR_BIT     5
`define GPS_FAST_WRITE_BIT    4
`define GPS_SPEED_MSB         2

// capability values
`define GPS_QUEUE_FIELD       8'h1f
`define GPS_QUEUE_DEPTH       6'h20
`define GPS_SPEED_CAPS        3'h7

// speed codes
`define GPS_SPEED_1X          3'h1
`define GPS_SPEED_2X          3'h2
`define GPS_SPEED_4X          3'h4

// sideband beats per command, by speed
`define GPS_SB_BEATS_1X       3'h4
`define GPS_SB_BEATS_2X       3'h2
`define GPS_SB_BEATS_4X       3'h1

`endif

// File: hw/gps_pkg.sv
package gps_pkg;

  // sideband receiver states
  typedef enum logic [2:0] {
    SB_IDLE  = 3'b001,
    SB_RECV  = 3'b010,
    SB_ISSUE = 3'b100
  } gps_sb_state_e;

  // software settings of the port
  typedef struct packed {
    logic       sideband_enable;
    logic       port_enable;
    logic       fast_write_enable;
    logic [2:0] transfer_speed_select;
  } gps_cmd_s;

  // host write carrier decision
  typedef struct packed {
    logic       use_fast;
    logic [2:0] speed;
  } gps_write_mode_s;

endpackage

// File: hw/gps_port_regs.sv
`include "gps_defines.svh"
// Function
// - queue field reads 1Fh, 32 requests
// - status bit 9 reads one
// - status bit 5 reads zero
// - status bit 4 reads one
// - status speed bits read 111
// - command bit 9 enables sideband
// - port disabled ignores all operations
// - accepted operations finish after disable
// - 1x sideband command issues despite disable
// - pipe needs enable; sideband needs both
// - fast write bit selects fast writes
// - fast writes run at selected speed
// - disabled or 1x uses plain writes
// - speed field keeps one-hot writes only; resets to 000
// - speed applies to all buses
module gps_port_regs (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  // ahb-lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  // port pins from the graphics master
  input  wire logic                     pipe_req_b,
  input  wire logic                     sideband_strobe,
  input  wire logic                     sideband_sync,
  // service logic on the same clock
  input  wire logic                     op_done,
  input  wire logic                     host_write_req,
  // port side results
  output logic                          pipe_accept,
  output logic                          sideband_issue,
  output logic                          sync_ack,
  output logic [5:0]                    pending_ops,
  output logic                          host_write_go,
  output gps_pkg::gps_write_mode_s      host_write_mode,
  output gps_pkg::gps_cmd_s             port_config
);

  // exactly one bit set in a speed code
  function automatic logic one_hot3(input logic [2:0] v);
    one_hot3 = (v == `GPS_SPEED_1X) || (v == `GPS_SPEED_2X) || (v == `GPS_SPEED_4X);
  endfunction

  // effective speed; illegal or reset code runs as 1x
  function automatic logic [2:0] eff_speed(input logic [2:0] v);
    eff_speed = one_hot3(v) ? v : `GPS_SPEED_1X;
  endfunction

  // sideband beats per command at a speed
  function automatic logic [2:0] sb_beats(input logic [2:0] v);
    unique case (eff_speed(v))
      `GPS_SPEED_2X: sb_beats = `GPS_SB_BEATS_2X;
      `GPS_SPEED_4X: sb_beats = `GPS_SB_BEATS_4X;
      default:       sb_beats = `GPS_SB_BEATS_1X;
    endcase
  endfunction

  gps_pkg::gps_cmd_s      cmd;          // command register state
  logic                   wr_pend;      // write data phase pending
  logic [7:0]             wr_addr;      // latched write address
  logic [31:0]            status_word;  // hardwired capability word
  logic [31:0]            cmd_word;     // command register as read
  logic [31:0]            next_rdata;   // read mux result
  logic                   addr_take;    // valid address phase
  logic [2:0]             pipe_sync;    // pipe request synchroniser
  logic [2:0]             strb_sync;    // sideband strobe synchroniser
  logic [2:0]             sync_sync;    // sync cycle synchroniser
  logic                   pipe_req;     // synchronised pipe request
  logic                   strb;         // synchronised strobe
  logic                   strb_prev;    // strobe, one cycle later
  logic                   sync_lvl;     // synchronised sync level
  logic                   sync_prev;    // sync level, one cycle later
  gps_pkg::gps_sb_state_e sb_state;     // sideband receiver state
  gps_pkg::gps_sb_state_e next_sb_state;
  logic [2:0]             sb_count;     // beats still to receive
  logic                   sb_is_1x;     // command began in 1x mode
  logic                   queue_full;   // no room for another op
  logic                   take_pipe;    // pipe op accepted now
  logic                   take_sb;      // sideband op issued now

  // capability word, reserved bits zero
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[31:`GPS_QUEUE_LSB] = `GPS_QUEUE_FIELD;
    status_word[`GPS_SIDEBAND_BIT] = 1'b1;
    status_word[`GPS_HIGH_ADDR_BIT] = 1'b0;
    status_word[`GPS_FAST_WRITE_BIT] = 1'b1;
    status_word[`GPS_SPEED_MSB:0] = `GPS_SPEED_CAPS;
  end

  // command word as read back
  always_comb
  begin
    cmd_word = 32'h0000_0000;
    cmd_word[`GPS_SIDEBAND_BIT] = cmd.sideband_enable;
    cmd_word[`GPS_PORT_EN_BIT] = cmd.port_enable;
    cmd_word[`GPS_FAST_WRITE_BIT] = cmd.fast_write_enable;
    cmd_word[`GPS_SPEED_MSB:0] = cmd.transfer_speed_select;
  end

  // a transfer addressed to this slave
  assign addr_take = hsel && hready && htrans[1];

  // read mux, unmapped reads zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (addr_take && !hwrite)
    begin
      unique case (haddr[7:0])
        `GPS_STATUS_OFS:  next_rdata = status_word;
        `GPS_COMMAND_OFS: next_rdata = cmd_word;
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // zero wait state, always okay
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data driven in the data phase
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      hrdata <= 32'h0000_0000;
    else if (hready)
      hrdata <= next_rdata;
  end

  // write address held for the data phase
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend <= addr_take && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // command register update
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      cmd <= gps_pkg::gps_cmd_s'(`GPS_COMMAND_RESET);
    else if (wr_pend && wr_addr == `GPS_COMMAND_OFS)
    begin
      cmd.sideband_enable   <= hwdata[`GPS_SIDEBAND_BIT];
      cmd.port_enable       <= hwdata[`GPS_PORT_EN_BIT];
      cmd.fast_write_enable <= hwdata[`GPS_FAST_WRITE_BIT];
      if (one_hot3(hwdata[`GPS_SPEED_MSB:0]))
        cmd.transfer_speed_select <= hwdata[`GPS_SPEED_MSB:0];
    end
  end

  // pin synchronisers, two flops before use
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pipe_sync <= 3'h0;
      strb_sync <= 3'h0;
      sync_sync <= 3'h0;
    end
    else
    begin
      pipe_sync <= {pipe_sync[1:0], !pipe_req_b};
      strb_sync <= {strb_sync[1:0], sideband_strobe};
      sync_sync <= {sync_sync[1:0], sideband_sync};
    end
  end

  // second stage outputs and edge history
  assign pipe_req  = pipe_sync[1];
  assign strb      = strb_sync[1];
  assign strb_prev = strb_sync[2];
  assign sync_lvl  = sync_sync[1];
  assign sync_prev = sync_sync[2];

  // queue holds at most the advertised depth, one more if a pipe accept and a sideband start share a cycle; a sideband command in flight keeps a slot
  assign queue_full = ({1'b0, pending_ops} + {6'h00, sb_state != gps_pkg::SB_IDLE}) >= {1'b0, `GPS_QUEUE_DEPTH};

  // pipe yields to a sideband issue so no count is lost
  // pipe ops need port enable only
  assign take_pipe = pipe_req && cmd.port_enable && !queue_full && !take_sb;

  // sideband receiver next state
  always_comb
  begin
    next_sb_state = sb_state;
    unique case (sb_state)
      gps_pkg::SB_IDLE:
      begin
        if (strb && !strb_prev && cmd.port_enable && cmd.sideband_enable && !queue_full)
          next_sb_state = gps_pkg::SB_RECV;
      end
      gps_pkg::SB_RECV:
      begin
        if (!cmd.port_enable && !sb_is_1x)
          next_sb_state = gps_pkg::SB_IDLE;
        else if (sb_count == 3'h1)
          next_sb_state = gps_pkg::SB_ISSUE;
      end
      gps_pkg::SB_ISSUE:
        next_sb_state = gps_pkg::SB_IDLE;
    endcase
  end

  // sideband state and beat counter
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sb_state <= gps_pkg::SB_IDLE;
      sb_count <= 3'h0;
      sb_is_1x <= 1'b0;
    end
    else
    begin
      sb_state <= next_sb_state;
      if (sb_state == gps_pkg::SB_IDLE)
      begin
        sb_count <= sb_beats(cmd.transfer_speed_select);
        sb_is_1x <= (eff_speed(cmd.transfer_speed_select) == `GPS_SPEED_1X);
      end
      else if (sb_state == gps_pkg::SB_RECV)
        sb_count <= sb_count - 3'h1;
    end
  end

  // sideband issue moment
  assign take_sb = (sb_state == gps_pkg::SB_ISSUE);

  // accept pulses to the service logic
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pipe_accept    <= 1'b0;
      sideband_issue <= 1'b0;
    end
    else
    begin
      pipe_accept    <= take_pipe;
      sideband_issue <= take_sb;
    end
  end

  // sync cycle acknowledge
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sync_ack <= 1'b0;
    else
      sync_ack <= sync_lvl && !sync_prev && cmd.port_enable;
  end

  // outstanding operation count
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      pending_ops <= 6'h00;
    else
    begin
      unique case ({take_pipe || take_sb, op_done && pending_ops != 6'h00})
        2'b10:   pending_ops <= pending_ops + 6'h01;
        2'b01:   pending_ops <= pending_ops - 6'h01;
        default: pending_ops <= pending_ops;
      endcase
    end
  end

  // host write carrier choice
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      host_write_go   <= 1'b0;
      host_write_mode <= '0;
    end
    else
    begin
      host_write_go <= host_write_req;
      if (host_write_req)
      begin
        // plain writes when off or 1x
        host_write_mode.use_fast <= cmd.fast_write_enable &&
          (eff_speed(cmd.transfer_speed_select) != `GPS_SPEED_1X);
        host_write_mode.speed <= eff_speed(cmd.transfer_speed_select);
      end
    end
  end

  // configuration seen by the port logic
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      port_config <= gps_pkg::gps_cmd_s'(`GPS_COMMAND_RESET);
    else
    begin
      port_config <= cmd;
      port_config.transfer_speed_select <= eff_speed(cmd.transfer_speed_select);
    end
  end

endmodule // gps_port_regs

// File: tb/gps_master_model.sv
module gps_master_model (
  // clock
  input wire logic clock,
  // port pins
  output logic     pipe_req_b,
  output logic     sideband_strobe,
  output logic     sideband_sync
);
  timeunit 1ns;
  timeprecision 1ps;

  // pins idle: no request, strobes low
  initial
  begin
    pipe_req_b = 1'b1;
    sideband_strobe = 1'b0;
    sideband_sync = 1'b0;
  end

  // pipe request held low for n cycles
  task automatic pipe(input int n);
    pipe_req_b <= 1'b0;
    repeat (n) @(posedge clock);
    pipe_req_b <= 1'b1;
  endtask

  // strobe (s=1) or sync (s=0) high for n cycles
  task automatic pulse(input bit s, input int n);
    if (s)
      sideband_strobe <= 1'b1;
    else
      sideband_sync <= 1'b1;
    repeat (n) @(posedge clock);
    sideband_strobe <= 1'b0;
    sideband_sync <= 1'b0;
    @(posedge clock);
  endtask
endmodule // gps_master_model

// File: tb/gps_port_properties.sv
module gps_port_properties (
  // clock and reset
  input wire logic                     clock,
  input wire logic                     rst_b,
  // service inputs
  input wire logic                     op_done,
  input wire logic                     host_write_req,
  // port results
  input wire logic                     pipe_accept,
  input wire logic                     sideband_issue,
  input wire logic                     sync_ack,
  input wire logic [5:0]               pending_ops,
  input wire logic                     host_write_go,
  input wire gps_pkg::gps_write_mode_s host_write_mode,
  input wire gps_pkg::gps_cmd_s        port_config
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_accept_gate: assert property (pipe_accept |-> port_config.port_enable && $past(pending_ops) < 6'h20)
    else $error("pipe accepted while off or full");
  a_sync_gate: assert property (sync_ack |-> port_config.port_enable)
    else $error("sync acked while port off");
  a_pend_up: assert property (pipe_accept && !$past(op_done) |-> pending_ops == $past(pending_ops) + 6'h01)
    else $error("pending count missed an accept");
  a_pend_down: assert property ($past(op_done) && !pipe_accept && !sideband_issue && $past(pending_ops) != 6'h00
    |-> pending_ops == $past(pending_ops) - 6'h01)
    else $error("pending count missed a completion");
  a_go_next: assert property (host_write_req |=> host_write_go)
    else $error("host write not launched");
  a_fast_mode: assert property (host_write_go |-> host_write_mode.use_fast ==
    (port_config.fast_write_enable && port_config.transfer_speed_select != 3'h1))
    else $error("wrong write carrier");
  a_fast_speed: assert property (host_write_go |-> host_write_mode.speed == port_config.transfer_speed_select)
    else $error("wrong fast write speed");
  a_speed_onehot: assert property (1'b1 |=> $onehot(port_config.transfer_speed_select))
    else $error("speed not one-hot");

  // main scenarios reached
  c_pipe: cover property (pipe_accept);
  c_issue: cover property (sideband_issue);
  c_fast: cover property (host_write_go && host_write_mode.use_fast);
endmodule // gps_port_properties

bind gps_port_regs gps_port_properties chk_u (.clock, .rst_b, .op_done, .host_write_req, .pipe_accept,
  .sideband_issue, .sync_ack, .pending_ops, .host_write_go, .host_write_mode, .port_config);

// File: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_b, hsel, hwrite, op_done, host_write_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        pipe_req_b, sideband_strobe, sideband_sync, hreadyout, hresp;
  logic        pipe_accept, sideband_issue, sync_ack, host_write_go;
  logic [5:0]  pending_ops;
  gps_pkg::gps_write_mode_s host_write_mode;
  gps_pkg::gps_cmd_s        port_config;
  int          n_errors, cmp_count, cyc, n_acc, n_iss, n_ack, a;

  // design under test, bus hready fed from its own hreadyout
  gps_port_regs dut_u (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pipe_req_b, .sideband_strobe, .sideband_sync,
    .op_done, .host_write_req, .pipe_accept, .sideband_issue, .sync_ack, .pending_ops,
    .host_write_go, .host_write_mode, .port_config);
  gps_master_model gm_u (.clock, .pipe_req_b, .sideband_strobe, .sideband_sync);

  // 40 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // pulse counters and hang guard
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    n_acc <= n_acc + int'(pipe_accept);
    n_iss <= n_iss + int'(sideband_issue);
    n_ack <= n_ack + int'(sync_ack);
    if (cyc == 5000)
    begin
      n_errors++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one single ahb transfer, read data left in rd
  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, ad};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // fixed fields, read-only and illegal writes
  task automatic t_regs();
    ahb(1'b1, 8'ha4, 32'h0000_0000);
    ahb(1'b0, 8'ha4, 32'h0000_0000);
    chk(rd, 32'h1f00_0217);
    chk(hresp, 32'h0000_0000);
    ahb(1'b1, 8'ha8, 32'hffff_ffff);
    ahb(1'b0, 8'ha8, 32'h0000_0000);
    chk(rd, 32'h0000_0310);
    ahb(1'b1, 8'ha8, 32'h0000_0002);
    ahb(1'b0, 8'ha8, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    ahb(1'b0, 8'hac, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ahb(1'b1, 8'ha8, 32'h0000_0000);
  endtask

  // port off, then fill queue, then drain with port off
  task automatic t_pipe();
    a = n_acc;
    gm_u.pipe(4);
    gm_u.pulse(1'b0, 2);
    repeat (4) @(posedge clock);
    chk(n_acc - a + n_ack, 0);
    ahb(1'b1, 8'ha8, 32'h0000_0100);
    a = n_acc;
    gm_u.pipe(36);
    repeat (4) @(posedge clock);
    chk(n_acc - a, 32);
    chk(pending_ops, 32);
    ahb(1'b1, 8'ha8, 32'h0000_0000);
    op_done <= 1'b1;
    repeat (32) @(posedge clock);
    op_done <= 1'b0;
    @(posedge clock);
    chk(pending_ops, 0);
  endtask

  // sideband gating and 1x command across disable
  task automatic t_sb();
    ahb(1'b1, 8'ha8, 32'h0000_0101);
    a = n_iss;
    gm_u.pulse(1'b1, 4);
    gm_u.pulse(1'b0, 2);
    repeat (10) @(posedge clock);
    chk(n_iss - a, 0);
    chk(n_ack, 1);
    ahb(1'b1, 8'ha8, 32'h0000_0301);
    gm_u.pulse(1'b1, 4);
    repeat (10) @(posedge clock);
    chk(n_iss - a, 1);
    // disable lands on an edge while the 1x command is being received
    fork
      gm_u.pulse(1'b1, 4);
      begin
        repeat (3) @(posedge clock);
        ahb(1'b1, 8'ha8, 32'h0000_0000);
      end
    join
    repeat (10) @(posedge clock);
    chk(n_iss - a, 2);
    // 4x sideband command, one beat
    ahb(1'b1, 8'ha8, 32'h0000_0304);
    gm_u.pulse(1'b1, 4);
    repeat (10) @(posedge clock);
    chk(n_iss - a, 3);
  endtask

  // write carrier for every speed, fast writes off and on
  task automatic t_fast();
    logic [2:0] sp;
    logic       fw;
    for (int i = 0; i < 6; i++)
    begin
      sp = 3'h1 << (i % 3);
      fw = (i > 2);
      ahb(1'b1, 8'ha8, {23'h0, 1'b1, 3'h0, fw, 1'b0, sp});
      host_write_req <= 1'b1;
      @(posedge clock);
      host_write_req <= 1'b0;
      @(posedge clock);
      chk({host_write_go, host_write_mode}, {1'b1, fw && sp != 3'h1, sp});
      chk(port_config.transfer_speed_select, sp);
    end
  endtask

  task automatic results();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // reset, then scenarios
  initial
  begin
    {rst_b, hsel, hwrite, op_done, host_write_req, htrans} = '0;
    {haddr, hwdata, cyc, n_acc, n_iss, n_ack} = '0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_regs();
    t_pipe();
    t_sb();
    t_fast();
    results();
  end
endmodule // tb
